// ### core/afr_filter_regs.v
`timescale 1ns/100ps
`include "afr_defines.vh"

// Behaviour
// - The promiscuous bit is one bit wide, 0 turns promiscuous reception off and 1 turns it on.
// - Filter-enable bit n (n = 0..3) enables the global filter, the extended filter and unit n.
// - A unit's reserved-type bit maps frame types 4 to 7 to data frames when 1, else drops them.
// - Coordinator bits 0 to 3 of the second configuration register make unit n a PAN coordinator.
// - A frame whose type indexes a zero bit of the eight-bit type mask is refused.
// - The type mask resets to 0x0b, passing beacon, data and command frames.
// - A frame whose version indexes a zero bit of the four-bit version mask is refused.
// - The version mask resets to 3, passing versions 0 and 1 only.
// - Status bit 4 is set when the extended filter matches the extended address.
// - Status bit n (n = 0..3) is set when unit n detects an address match.
// - All five match flags clear at a frame start event, except a flag set by a header match in the same cycle.
// - The low 40 bits of the extended address are held in five bytes, byte n carrying bits 8n+7 to 8n, reset zero; bits 63 to 40 come from extAddrUpper.
// - The acknowledge pending bit is the pending bit of the lowest-numbered unit that reported a match.

module afr_filter_regs #(
    parameter UNITS = 4,
    parameter EXT_LOW_BYTES = 5
) (
    input wire sys_clk,
    input wire reset,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output wire [7:0] regRdData,
    input wire [23:0] extAddrUpper,
    input wire [16*UNITS-1:0] unitPanIds,
    input wire [16*UNITS-1:0] unitShortAddrs,
    input wire [UNITS-1:0] ackPendingBits,
    input wire frameStartEvent,
    input wire hdrValid,
    input wire [2:0] frameType,
    input wire [1:0] frameVersion,
    input wire [1:0] dstAddrMode,
    input wire [15:0] dstPanId,
    input wire [15:0] dstShortAddr,
    input wire [63:0] dstExtAddr,
    input wire [1:0] srcAddrMode,
    input wire [15:0] srcPanId,
    output reg frameDecided,
    output reg frameAccept,
    output reg ackPendingOut,
    output wire filterActive,
    output wire acceptAllFrames,
    output wire [4:0] matchFlags
);
    // Configuration registers
    reg acceptAll_reg;
    reg [UNITS-1:0] unitFilterOn_reg;
    reg [UNITS-1:0] unitReservedAsData_reg;
    reg [UNITS-1:0] unitCoordinatorRole_reg;
    reg [7:0] typeAcceptMask_reg;
    reg [3:0] versionAcceptMask_reg;

    // Status registers
    reg longAddrHit_reg;
    reg longAddrHit_next;
    reg [UNITS-1:0] unitAddrHit_reg;
    reg [UNITS-1:0] unitAddrHit_next;
    reg [2:0] lastReason_reg;
    reg [2:0] lastReason_next;

    // Read path
    reg [7:0] localRdData_reg;
    reg [7:0] localRdData_next;
    reg rdFromStore_reg;

    // Decision path
    reg decide_next;
    reg accept_next;
    reg pending_next;

    wire [8*EXT_LOW_BYTES-1:0] extLowBytes;
    wire [7:0] storeRdData;
    wire [63:0] longAddr;
    wire [UNITS-1:0] unitHit;
    wire [UNITS-1:0] unitHitMasked;
    wire storeHit;
    wire [2:0] storeIdx;
    wire typePass;
    wire versionPass;
    wire globalPass;
    wire longMatch;

    // Address decode of the extended address byte window
    function isStoreAddr;
        input [7:0] addr;
        begin
            isStoreAddr = (addr >= `AFR_OFS_EXT_BYTE0) && (addr <= `AFR_OFS_EXT_BYTE4);
        end
    endfunction

    function [2:0] storeIndex;
        input [7:0] addr;
        reg [7:0] diff;
        begin
            diff = addr - `AFR_OFS_EXT_BYTE0;
            storeIndex = diff[2:0];
        end
    endfunction

    // Lowest set bit of a unit vector
    function [UNITS-1:0] firstSet;
        input [UNITS-1:0] vec;
        integer k;
        reg found;
        begin
            firstSet = {UNITS{1'b0}};
            found = 1'b0;
            for (k = 0; k < UNITS; k = k + 1) begin
                if (vec[k] && !found) begin
                    firstSet[k] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    endfunction

    assign storeHit = isStoreAddr(regAddr);
    assign storeIdx = storeIndex(regAddr);

    afr_ext_addr_store #(
        .BYTES(EXT_LOW_BYTES)
    ) extStore (
        .sys_clk(sys_clk),
        .reset(reset),
        .wrEn(regWrEn && storeHit),
        .wrIdx(storeIdx),
        .wrData(regWrData),
        .rdEn(regRdEn && storeHit),
        .rdIdx(storeIdx),
        .rdData(storeRdData),
        .storeFlat(extLowBytes)
    );

    assign longAddr = {extAddrUpper, extLowBytes};

    // Any enable bit switches on the global and extended stages
    assign filterActive = |unitFilterOn_reg;
    assign acceptAllFrames = acceptAll_reg;

    assign typePass = typeAcceptMask_reg[frameType];
    assign versionPass = versionAcceptMask_reg[frameVersion];
    assign globalPass = typePass && versionPass;

    assign longMatch = filterActive && globalPass
        && (dstAddrMode == `AFR_AM_EXT) && (dstExtAddr == longAddr);

    genvar u;
    generate
        for (u = 0; u < UNITS; u = u + 1) begin : unit
            afr_unit_match match (
                .unitOn(unitFilterOn_reg[u]),
                .reservedAsData(unitReservedAsData_reg[u]),
                .coordinatorRole(unitCoordinatorRole_reg[u]),
                .panId(unitPanIds[16*u+15:16*u]),
                .shortAddr(unitShortAddrs[16*u+15:16*u]),
                .extAddr(longAddr),
                .frameType(frameType),
                .dstMode(dstAddrMode),
                .dstPan(dstPanId),
                .dstShort(dstShortAddr),
                .dstExt(dstExtAddr),
                .srcMode(srcAddrMode),
                .srcPan(srcPanId),
                .hit(unitHit[u])
            );
        end
    endgenerate

    // Units only see frames that passed the global stage
    assign unitHitMasked = globalPass ? unitHit : {UNITS{1'b0}};

    assign matchFlags = {longAddrHit_reg, unitAddrHit_reg};
    assign regRdData = rdFromStore_reg ? storeRdData : localRdData_reg;

    // Flag update, a hit in the clearing cycle wins
    always @* begin
        longAddrHit_next = longAddrHit_reg;
        unitAddrHit_next = unitAddrHit_reg;
        if (frameStartEvent) begin
            longAddrHit_next = 1'b0;
            unitAddrHit_next = {UNITS{1'b0}};
        end
        if (hdrValid) begin
            longAddrHit_next = longAddrHit_next | longMatch;
            unitAddrHit_next = unitAddrHit_next | unitHitMasked;
        end
    end

    // Frame decision
    always @* begin
        decide_next = hdrValid;
        accept_next = 1'b0;
        pending_next = 1'b0;
        lastReason_next = lastReason_reg;
        if (hdrValid) begin
            if (acceptAll_reg == `AFR_PROMISC_ON) begin
                accept_next = 1'b1;
                lastReason_next = `AFR_WHY_PROMISC;
            end else if (!filterActive) begin
                accept_next = 1'b1;
                lastReason_next = `AFR_WHY_OFF;
            end else if (!typePass) begin
                lastReason_next = `AFR_WHY_TYPE;
            end else if (!versionPass) begin
                lastReason_next = `AFR_WHY_VERSION;
            end else if (|unitHitMasked) begin
                accept_next = 1'b1;
                lastReason_next = `AFR_WHY_UNIT;
            end else begin
                lastReason_next = `AFR_WHY_NO_UNIT;
            end
            pending_next = |(firstSet(unitHitMasked) & ackPendingBits);
        end
    end

    // Register read data
    always @* begin
        localRdData_next = localRdData_reg;
        if (regRdEn) begin
            case (regAddr)
                `AFR_OFS_CFG0: begin
                    localRdData_next = {3'h0, acceptAll_reg, unitFilterOn_reg};
                end
                `AFR_OFS_CFG1: begin
                    localRdData_next = {unitReservedAsData_reg, unitCoordinatorRole_reg};
                end
                `AFR_OFS_TYPE_MASK: begin
                    localRdData_next = typeAcceptMask_reg;
                end
                `AFR_OFS_VERSION_MASK: begin
                    localRdData_next = {4'h0, versionAcceptMask_reg};
                end
                `AFR_OFS_STATUS: begin
                    localRdData_next = {3'h0, longAddrHit_reg, unitAddrHit_reg};
                end
                `AFR_OFS_LAST_RESULT: begin
                    localRdData_next = {5'h00, lastReason_reg};
                end
                default: begin
                    localRdData_next = 8'h00;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            acceptAll_reg <= `AFR_PROMISC_OFF;
            unitFilterOn_reg <= {UNITS{1'b0}};
            unitReservedAsData_reg <= {UNITS{1'b0}};
            unitCoordinatorRole_reg <= {UNITS{1'b0}};
            typeAcceptMask_reg <= `AFR_TYPE_MASK_RESET;
            versionAcceptMask_reg <= `AFR_VERSION_MASK_RESET;
        end else if (regWrEn) begin
            case (regAddr)
                `AFR_OFS_CFG0: begin
                    acceptAll_reg <= regWrData[`AFR_CFG0_PROMISC_BIT];
                    unitFilterOn_reg <= regWrData[UNITS-1:0];
                end
                `AFR_OFS_CFG1: begin
                    unitReservedAsData_reg <= regWrData[7:4];
                    unitCoordinatorRole_reg <= regWrData[3:0];
                end
                `AFR_OFS_TYPE_MASK: begin
                    typeAcceptMask_reg <= regWrData;
                end
                `AFR_OFS_VERSION_MASK: begin
                    versionAcceptMask_reg <= regWrData[3:0];
                end
                default: begin
                    acceptAll_reg <= acceptAll_reg;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            longAddrHit_reg <= 1'b0;
            unitAddrHit_reg <= {UNITS{1'b0}};
            lastReason_reg <= `AFR_WHY_NONE;
            localRdData_reg <= 8'h00;
            rdFromStore_reg <= 1'b0;
            frameDecided <= 1'b0;
            frameAccept <= 1'b0;
            ackPendingOut <= 1'b0;
        end else begin
            longAddrHit_reg <= longAddrHit_next;
            unitAddrHit_reg <= unitAddrHit_next;
            lastReason_reg <= lastReason_next;
            localRdData_reg <= localRdData_next;
            if (regRdEn) begin
                rdFromStore_reg <= storeHit;
            end
            frameDecided <= decide_next;
            frameAccept <= accept_next;
            if (hdrValid) begin
                ackPendingOut <= pending_next;
            end
        end
    end
endmodule // afr_filter_regs

// ### shared/afr_defines.vh
`ifndef AFR_DEFINES_VH
`define AFR_DEFINES_VH

// Register offsets
`define AFR_OFS_CFG0 8'h00
`define AFR_OFS_CFG1 8'h01
`define AFR_OFS_TYPE_MASK 8'h02
`define AFR_OFS_VERSION_MASK 8'h03
`define AFR_OFS_STATUS 8'h04
`define AFR_OFS_EXT_BYTE0 8'h05
`define AFR_OFS_EXT_BYTE4 8'h09
`define AFR_OFS_LAST_RESULT 8'h0a

// Field positions
`define AFR_CFG0_PROMISC_BIT 4
`define AFR_STATUS_LONG_HIT_BIT 4

// Reset values
`define AFR_CFG0_RESET 8'h00
`define AFR_CFG1_RESET 8'h00
`define AFR_TYPE_MASK_RESET 8'h0b
`define AFR_VERSION_MASK_RESET 4'h3
`define AFR_STATUS_RESET 5'h00
`define AFR_PROMISC_OFF 1'h0
`define AFR_PROMISC_ON 1'h1

// Frame types and addressing modes
`define AFR_FT_BEACON 3'h0
`define AFR_FT_DATA 3'h1
`define AFR_FT_CMD 3'h3
`define AFR_FT_FIRST_RESERVED 3'h4
`define AFR_AM_NONE 2'h0
`define AFR_AM_SHORT 2'h2
`define AFR_AM_EXT 2'h3
`define AFR_BCAST16 16'hffff

// Decision reason codes
`define AFR_WHY_NONE 3'h0
`define AFR_WHY_OFF 3'h1
`define AFR_WHY_PROMISC 3'h2
`define AFR_WHY_TYPE 3'h3
`define AFR_WHY_VERSION 3'h4
`define AFR_WHY_NO_UNIT 3'h5
`define AFR_WHY_UNIT 3'h6

`endif

// ### core/afr_ext_addr_store.v
`timescale 1ns/100ps
`include "afr_defines.vh"

module afr_ext_addr_store #(
    parameter BYTES = 5
) (
    input wire sys_clk,
    input wire reset,
    input wire wrEn,
    input wire [2:0] wrIdx,
    input wire [7:0] wrData,
    input wire rdEn,
    input wire [2:0] rdIdx,
    output reg [7:0] rdData,
    output wire [8*BYTES-1:0] storeFlat
);
    reg [7:0] byteMem [0:BYTES-1];
    integer i;

    // Byte n holds address bits 8n+7 down to 8n
    genvar g;
    generate
        for (g = 0; g < BYTES; g = g + 1) begin : flat
            assign storeFlat[8*g+7:8*g] = byteMem[g];
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (reset) begin
            for (i = 0; i < BYTES; i = i + 1) begin
                byteMem[i] <= 8'h00;
            end
            rdData <= 8'h00;
        end else begin
            if (wrEn && (wrIdx < BYTES)) begin
                byteMem[wrIdx] <= wrData;
            end
            if (rdEn) begin
                rdData <= (rdIdx < BYTES) ? byteMem[rdIdx] : 8'h00;
            end
        end
    end
endmodule // afr_ext_addr_store

// ### core/afr_unit_match.v
`timescale 1ns/100ps
`include "afr_defines.vh"

module afr_unit_match (
    input wire unitOn,
    input wire reservedAsData,
    input wire coordinatorRole,
    input wire [15:0] panId,
    input wire [15:0] shortAddr,
    input wire [63:0] extAddr,
    input wire [2:0] frameType,
    input wire [1:0] dstMode,
    input wire [15:0] dstPan,
    input wire [15:0] dstShort,
    input wire [63:0] dstExt,
    input wire [1:0] srcMode,
    input wire [15:0] srcPan,
    output reg hit
);
    reg reserved;
    reg dataLike;
    reg panOk;

    always @* begin
        reserved = (frameType >= `AFR_FT_FIRST_RESERVED);
        // Reserved types become data or are dropped
        dataLike = (frameType == `AFR_FT_DATA) || (frameType == `AFR_FT_CMD)
            || (reserved && reservedAsData);
        panOk = (dstPan == panId) || (dstPan == `AFR_BCAST16);
        hit = 1'b0;
        if (unitOn) begin
            if (frameType == `AFR_FT_BEACON) begin
                hit = (dstMode == `AFR_AM_NONE) && (srcMode != `AFR_AM_NONE)
                    && ((panId == `AFR_BCAST16) || (srcPan == panId));
            end else if (dataLike) begin
                case (dstMode)
                    `AFR_AM_SHORT: begin
                        hit = panOk && ((dstShort == shortAddr)
                            || (dstShort == `AFR_BCAST16));
                    end
                    `AFR_AM_EXT: begin
                        hit = panOk && (dstExt == extAddr);
                    end
                    `AFR_AM_NONE: begin
                        // Only a coordinator takes data-like frames without destination
                        hit = coordinatorRole && (srcMode != `AFR_AM_NONE)
                            && (srcPan == panId);
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // afr_unit_match

// ### tb/afr_filter_regs_props.sv
`timescale 1ns/100ps
module afr_filter_regs_props #(
    parameter UNITS = 4
) (
    input logic sys_clk,
    input logic reset,
    input logic [7:0] regRdData,
    input logic regRdEn,
    input logic [UNITS-1:0] ackPendingBits,
    input logic frameStartEvent,
    input logic hdrValid,
    input logic frameDecided,
    input logic frameAccept,
    input logic ackPendingOut,
    input logic filterActive,
    input logic acceptAllFrames,
    input logic [4:0] matchFlags
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_decide_next: assert property (hdrValid |=> frameDecided)
        else $error("no decision after header");
    a_accept_cause: assert property (frameAccept |-> frameDecided && $past(hdrValid))
        else $error("accept without header");
    a_promisc_accept: assert property (hdrValid && acceptAllFrames |=> frameAccept)
        else $error("promiscuous frame refused");
    a_filter_off: assert property (hdrValid && !filterActive |=> frameAccept)
        else $error("frame refused with filter off");
    a_flags_clear: assert property (frameStartEvent && !hdrValid |=> matchFlags == 5'h00)
        else $error("flags not cleared at frame start");
    a_flags_hold: assert property (!frameStartEvent && !hdrValid |=> $stable(matchFlags))
        else $error("flags changed without frame");
    a_no_hit_flags: assert property (hdrValid && !filterActive && !frameStartEvent
        |=> matchFlags == $past(matchFlags))
        else $error("hit recorded with filter off");
    a_ack_no_hit: assert property (frameDecided && matchFlags[3:0] == 4'h0 |-> !ackPendingOut)
        else $error("pending set without unit hit");
    a_ack_unit0: assert property (frameDecided && matchFlags[0] && !$past(matchFlags[0])
        |-> ackPendingOut == $past(ackPendingBits[0]))
        else $error("pending bit not from unit 0");
    a_read_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
endmodule // afr_filter_regs_props

bind afr_filter_regs afr_filter_regs_props #(.UNITS(UNITS)) i_props (
    .sys_clk(sys_clk),
    .reset(reset),
    .regRdData(regRdData),
    .regRdEn(regRdEn),
    .ackPendingBits(ackPendingBits),
    .frameStartEvent(frameStartEvent),
    .hdrValid(hdrValid),
    .frameDecided(frameDecided),
    .frameAccept(frameAccept),
    .ackPendingOut(ackPendingOut),
    .filterActive(filterActive),
    .acceptAllFrames(acceptAllFrames),
    .matchFlags(matchFlags)
);

// ### tb/afr_filter_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module afr_filter_regs_tb;
    logic sys_clk = 0, reset = 1, regWrEn = 0, regRdEn = 0, frameStartEvent = 0, hdrValid = 0;
    logic [7:0] regAddr = 0, regWrData = 0, re;
    logic [23:0] extAddrUpper = 0;
    logic [63:0] unitPanIds = 0, unitShortAddrs = 0, dstExtAddr = 0;
    logic [3:0] ackPendingBits = 0;
    logic [2:0] frameType = 0;
    logic [1:0] frameVersion = 0, dstAddrMode = 0, srcAddrMode = 0;
    logic [15:0] dstPanId = 0, dstShortAddr = 0, srcPanId = 0, pan, sh;
    logic [39:0] extLow;
    logic [8:0] fm, fe;
    logic rdSeen = 0;
    logic [7:0] rdQ[$];
    logic [8:0] frQ[$], frM[$];
    logic [7:0] rv[0:10] = '{8'h00, 8'h00, 8'h0b, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    wire [7:0] regRdData;
    wire frameDecided, frameAccept, ackPendingOut, filterActive, acceptAllFrames;
    wire [4:0] matchFlags;
    int fails = 0, checks = 0, i;

    afr_filter_regs i_dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .extAddrUpper(extAddrUpper), .unitPanIds(unitPanIds), .unitShortAddrs(unitShortAddrs),
        .ackPendingBits(ackPendingBits), .frameStartEvent(frameStartEvent),
        .hdrValid(hdrValid), .frameType(frameType), .frameVersion(frameVersion),
        .dstAddrMode(dstAddrMode), .dstPanId(dstPanId), .dstShortAddr(dstShortAddr),
        .dstExtAddr(dstExtAddr), .srcAddrMode(srcAddrMode), .srcPanId(srcPanId),
        .frameDecided(frameDecided), .frameAccept(frameAccept), .ackPendingOut(ackPendingOut),
        .filterActive(filterActive), .acceptAllFrames(acceptAllFrames), .matchFlags(matchFlags));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk); #1;
        regAddr = a; regWrData = d; regWrEn = 1;
        @(posedge sys_clk); #1;
        regWrEn = 0;
    endtask

    task rd(input [7:0] a, input [7:0] e);
        @(posedge sys_clk); #1;
        regAddr = a; regRdEn = 1; rdQ.push_back(e);
        @(posedge sys_clk); #1;
        regRdEn = 0;
    endtask

    task frm(input [2:0] t, input [1:0] v, input [1:0] dm, input [8:0] e, input [8:0] m);
        @(posedge sys_clk); #1;
        frameType = t; frameVersion = v; dstAddrMode = dm; hdrValid = 1;
        frQ.push_back(e); frM.push_back(m);
        @(posedge sys_clk); #1;
        hdrValid = 0;
        @(posedge sys_clk);
    endtask

    task fs();
        @(posedge sys_clk); #1;
        frameStartEvent = 1;
        @(posedge sys_clk); #1;
        frameStartEvent = 0;
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    task summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) rdSeen <= regRdEn;

    always @(negedge sys_clk) begin
        if (rdSeen) begin
            re = rdQ.pop_front();
            `CHK(regRdData, re)
        end
        if (frameDecided === 1'b1) begin
            fm = frM.pop_front();
            fe = frQ.pop_front();
            `CHK({acceptAllFrames, filterActive, frameAccept, ackPendingOut, matchFlags} & fm,
                fe & fm)
        end
    end

    initial begin
        #20000;
        fails++;
        summarize();
    end

    initial begin
        void'($urandom(4));
        pan = 16'($urandom % 16'hffff);
        sh = 16'($urandom % 16'hfffe) + 16'h0001;
        extLow = {8'($urandom), 32'($urandom)};
        extAddrUpper = 24'($urandom);
        unitPanIds = {4{pan}};
        unitShortAddrs = {4{sh}};
        dstPanId = pan;
        srcPanId = pan;
        dstShortAddr = sh;
        srcAddrMode = 2'h2;
        repeat (16) @(posedge sys_clk);
        #1 reset = 0;
        for (i = 0; i < 11; i++) rd(8'(i), rv[i]);
        rd(8'h20, 8'h00);
        done("reset values");
        for (i = 0; i < 5; i++) wr(8'(5 + i), extLow[8*i +: 8]);
        for (i = 0; i < 5; i++) rd(8'(5 + i), extLow[8*i +: 8]);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h0f);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        wr(8'h01, 8'h5a);
        rd(8'h01, 8'h5a);
        wr(8'h01, 8'h00);
        wr(8'h03, 8'h03);
        done("register access");
        frm(3'h1, 2'h0, 2'h2, 9'h040, 9'h1ff);
        rd(8'h0a, 8'h01);
        wr(8'h00, 8'h04);
        ackPendingBits = 4'h4;
        frm(3'h1, 2'h0, 2'h2, 7'h64, 7'h7f);
        fs();
        rd(8'h04, 8'h00);
        wr(8'h00, 8'h01);
        ackPendingBits = 4'h2;
        frm(3'h1, 2'h0, 2'h2, 7'h41, 7'h7f);
        rd(8'h04, 8'h01);
        done("unit match");
        fs();
        frm(3'h2, 2'h0, 2'h2, 7'h00, 7'h40);
        wr(8'h02, 8'h09);
        frm(3'h1, 2'h0, 2'h2, 7'h00, 7'h7f);
        wr(8'h02, 8'h0b);
        frm(3'h1, 2'h2, 2'h2, 7'h00, 7'h7f);
        wr(8'h03, 8'h07);
        fs();
        frm(3'h1, 2'h2, 2'h2, 7'h41, 7'h5f);
        wr(8'h03, 8'h03);
        done("masks");
        wr(8'h02, 8'hf3);
        for (i = 4; i < 8; i++) frm(3'(i), 2'h0, 2'h2, 7'h00, 7'h40);
        wr(8'h01, 8'h10);
        for (i = 4; i < 8; i++) frm(3'(i), 2'h0, 2'h2, 7'h40, 7'h40);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h0b);
        frm(3'h1, 2'h0, 2'h0, 7'h00, 7'h40);
        frm(3'h0, 2'h0, 2'h0, 7'h40, 7'h40);
        wr(8'h01, 8'h01);
        frm(3'h1, 2'h0, 2'h0, 7'h40, 7'h40);
        wr(8'h01, 8'h00);
        done("reserved and coordinator");
        fs();
        dstExtAddr = {extAddrUpper, extLow};
        frm(3'h1, 2'h0, 2'h3, 7'h50, 7'h50);
        rd(8'h04, 8'h11);
        fs();
        dstExtAddr[33] = ~dstExtAddr[33];
        frm(3'h1, 2'h0, 2'h3, 7'h00, 7'h50);
        done("extended");
        dstShortAddr = ~sh;
        wr(8'h00, 8'h11);
        rd(8'h00, 8'h11);
        frm(3'h1, 2'h0, 2'h2, 9'h1c0, 9'h1c0);
        rd(8'h0a, 8'h02);
        wr(8'h00, 8'h01);
        frm(3'h1, 2'h0, 2'h2, 9'h080, 9'h1c0);
        rd(8'h0a, 8'h05);
        done("promiscuous");
        repeat (4) @(posedge sys_clk);
        summarize();
    end
endmodule // afr_filter_regs_tb
